/* bert_pkg.sv */
// Shared constants and carrier types for the test pattern block
package bert_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] CONTROL_ONE_OFFSET = 8'h00;
   localparam logic [7:0] CONFIG_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   // ==========================================
   // Field positions
   localparam int unsigned PATTERN_TYPE_BIT = 7;
   localparam int unsigned ERROR_INSERT_BIT = 6;
   localparam int unsigned DATA_INVERT_BIT = 5;
   localparam int unsigned SWITCH_BIT = 0;
   localparam int unsigned GEN_ENABLE_BIT = 1;
   localparam int unsigned CHECK_ENABLE_BIT = 2;
   localparam int unsigned LOCK_BIT = 0;
   localparam int unsigned ERR_COUNT_LSB = 8;
   localparam logic [7:0] CONTROL_ONE_MASK = 8'hE0;
   // ==========================================
   // Reset values
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic [19:0] GEN_SEED = 20'h00001;
   // ==========================================
   // Pattern construction and lock counts
   localparam int unsigned PRBS15_TAP_A = 14;
   localparam int unsigned PRBS15_TAP_B = 13;
   localparam int unsigned QRTS_TAP_A = 19;
   localparam int unsigned QRTS_TAP_B = 16;
   localparam logic [4:0] QRTS_ZERO_LIMIT = 5'h0E;
   localparam logic [4:0] ZERO_RUN_MAX = 5'h1F;
   localparam logic [5:0] LOCK_MATCHES = 6'h20;
   localparam logic [2:0] UNLOCK_MISSES = 3'h4;
   localparam logic [7:0] ERR_COUNT_MAX = 8'hFF;
   // ==========================================
   // Types
   typedef struct packed {
      logic to_backplane;
      logic data;
   } stream_word_type;
   typedef enum logic {HUNTING, LOCKED} lock_state_type;
endpackage

/* pattern_step.sv */
// One step of the test pattern sequence, shared by generator and checker
`timescale 1ns/1ps
module pattern_step (
   input wire logic [19:0] history_i,
   input wire logic qrts_i,
   input wire logic [4:0] zero_run_i,
   output logic feedback_o,
   output logic bit_o
);
   logic stuck;

   always_comb
   begin
      stuck = qrts_i ? (history_i == 20'h00000) : (history_i[14:0] == 15'h0000);
      if (stuck)
      begin
         feedback_o = 1'b1;
      end
      else if (qrts_i)
      begin
         feedback_o = history_i[bert_pkg::QRTS_TAP_A] ^ history_i[bert_pkg::QRTS_TAP_B];
      end
      else
      begin
         feedback_o = history_i[bert_pkg::PRBS15_TAP_A] ^ history_i[bert_pkg::PRBS15_TAP_B];
      end
      bit_o = feedback_o | (qrts_i & (zero_run_i >= bert_pkg::QRTS_ZERO_LIMIT));
   end
endmodule

/* two_entry_buffer.sv */
// Two-entry stream buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire bert_pkg::stream_word_type in_word_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output bert_pkg::stream_word_type out_word_o
);
   typedef struct packed {
      logic valid0;
      logic valid1;
      bert_pkg::stream_word_type word0;
      bert_pkg::stream_word_type word1;
   } buffer_state_type;

   buffer_state_type r;
   buffer_state_type next_r;

   always_comb
   begin
      next_r = r;
      if (r.valid0 & out_ready_i)
      begin
         next_r.valid0 = r.valid1;
         next_r.word0 = r.word1;
         next_r.valid1 = 1'b0;
      end
      if (in_valid_i & ~r.valid1)
      begin
         if (!next_r.valid0)
         begin
            next_r.valid0 = 1'b1;
            next_r.word0 = in_word_i;
         end
         else
         begin
            next_r.valid1 = 1'b1;
            next_r.word1 = in_word_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
      end
      else if (ce_i)
      begin
         r <= next_r;
      end
   end

   assign in_ready_o = ~r.valid1;
   assign out_valid_o = r.valid0;
   assign out_word_o = r.word0;
endmodule

/* bert_pattern_control.sv */
// Test pattern generation, error insertion, inversion and checking with a Wishbone register file
`timescale 1ns/1ps
// What this block does
// - Type bit 0 selects PRBS15 x^15+x^14+1, 1 selects QRTS, for both directions.
// - Switch off: generated pattern is sent toward the line interface.
// - Switch on: generated pattern goes out on the receive backplane instead.
// - Error-insert 0 to 1 change inverts exactly one output bit; holding inserts none.
// - Error insertion works only while generation is enabled; otherwise ignored.
// - Inserted error appears on the line or backplane output per switch.
// - Switch off, invert set: invert generated data and incoming data before checking.
// - Switch on, invert set: invert generated data and incoming data before checking.
// - Invert 0 leaves generated and received data unchanged; 1 inverts both.
module bert_pattern_control (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic out_valid_o,
   output logic out_data_o,
   output logic out_to_backplane_o,
   input wire logic out_ready_i,
   input wire logic in_valid_i,
   input wire logic in_data_i,
   output logic lock_o
);
   // ==========================================
   // State
   typedef struct packed {
      logic [7:0] control_one;
      logic [2:0] config_bits;
      logic ack;
      logic [31:0] rdata;
      logic insert_prev;
      logic insert_pending;
      logic [19:0] gen_hist;
      logic [4:0] gen_zero;
      logic [19:0] chk_hist;
      logic [4:0] chk_zero;
      bert_pkg::lock_state_type lock_state;
      logic locked;
      logic [5:0] match_run;
      logic [2:0] miss_run;
      logic [7:0] err_count;
   } block_state_type;

   block_state_type r;
   block_state_type next_r;

   logic bus_req;
   logic [5:0] word_adr;
   logic qrts;
   logic invert;
   logic switch_on;
   logic gen_en;
   logic chk_en;
   logic insert_edge;
   logic gen_feedback;
   logic gen_bit;
   logic chk_bit;
   logic push_valid;
   logic push_ready;
   logic chk_take;
   logic rx_bit;
   logic mismatch;
   logic clear_count;
   bert_pkg::stream_word_type push_word;
   bert_pkg::stream_word_type head_word;

   // ==========================================
   // Decoded controls
   assign qrts = r.control_one[bert_pkg::PATTERN_TYPE_BIT];
   assign invert = r.control_one[bert_pkg::DATA_INVERT_BIT];
   assign switch_on = r.config_bits[bert_pkg::SWITCH_BIT];
   assign gen_en = r.config_bits[bert_pkg::GEN_ENABLE_BIT];
   assign chk_en = r.config_bits[bert_pkg::CHECK_ENABLE_BIT];
   assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
   assign word_adr = wb_adr_i[7:2];

   // ==========================================
   // Sequence steps
   pattern_step gen_step (
      .history_i(r.gen_hist),
      .qrts_i(qrts),
      .zero_run_i(r.gen_zero),
      .feedback_o(gen_feedback),
      .bit_o(gen_bit)
   );

   pattern_step chk_step (
      .history_i(r.chk_hist),
      .qrts_i(qrts),
      .zero_run_i(r.chk_zero),
      .feedback_o(),
      .bit_o(chk_bit)
   );

   // ==========================================
   // Output stream buffer
   two_entry_buffer out_buffer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_word_i(push_word),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_word_o(head_word)
   );

   assign out_data_o = head_word.data;
   assign out_to_backplane_o = head_word.to_backplane;

   // ==========================================
   // Generator path
   always_comb
   begin
      insert_edge = r.control_one[bert_pkg::ERROR_INSERT_BIT] & ~r.insert_prev;
      push_valid = gen_en;
      push_word.data = gen_bit ^ invert ^ r.insert_pending;
      push_word.to_backplane = switch_on;
   end

   // ==========================================
   // Checker path
   always_comb
   begin
      chk_take = in_valid_i & chk_en;
      rx_bit = in_data_i ^ invert;
      mismatch = rx_bit != chk_bit;
      clear_count = bus_req & wb_we_i & wb_sel_i[1] & (word_adr == bert_pkg::STATUS_OFFSET[7:2]);
   end

   // ==========================================
   // Next state
   always_comb
   begin
      next_r = r;
      next_r.ack = bus_req;

      // ==========================================
      // Register writes
      if (bus_req & wb_we_i & wb_sel_i[0])
      begin
         if (word_adr == bert_pkg::CONTROL_ONE_OFFSET[7:2])
         begin
            next_r.control_one = wb_dat_i[7:0] & bert_pkg::CONTROL_ONE_MASK;
         end
         else if (word_adr == bert_pkg::CONFIG_OFFSET[7:2])
         begin
            next_r.config_bits = wb_dat_i[2:0];
         end
      end

      // ==========================================
      // Register reads
      next_r.rdata = 32'h00000000;
      if (bus_req & ~wb_we_i)
      begin
         if (word_adr == bert_pkg::CONTROL_ONE_OFFSET[7:2])
         begin
            next_r.rdata[7:0] = r.control_one;
         end
         else if (word_adr == bert_pkg::CONFIG_OFFSET[7:2])
         begin
            next_r.rdata[2:0] = r.config_bits;
         end
         else if (word_adr == bert_pkg::STATUS_OFFSET[7:2])
         begin
            next_r.rdata[bert_pkg::LOCK_BIT] = r.locked;
            next_r.rdata[bert_pkg::ERR_COUNT_LSB +: 8] = r.err_count;
         end
      end

      // ==========================================
      // Single error insertion, set wins over consumption
      next_r.insert_prev = r.control_one[bert_pkg::ERROR_INSERT_BIT];
      if (push_valid & push_ready)
      begin
         next_r.insert_pending = 1'b0;
      end
      if (insert_edge & gen_en)
      begin
         next_r.insert_pending = 1'b1;
      end
      if (!gen_en)
      begin
         next_r.insert_pending = 1'b0;
      end

      // ==========================================
      // Generator advance
      if (push_valid & push_ready)
      begin
         next_r.gen_hist = {r.gen_hist[18:0], gen_feedback};
         if (gen_bit)
         begin
            next_r.gen_zero = 5'h00;
         end
         else if (r.gen_zero != bert_pkg::ZERO_RUN_MAX)
         begin
            next_r.gen_zero = r.gen_zero + 5'h01;
         end
      end

      // ==========================================
      // Checker history
      if (chk_take)
      begin
         next_r.chk_hist = {r.chk_hist[18:0], rx_bit};
         if (rx_bit)
         begin
            next_r.chk_zero = 5'h00;
         end
         else if (r.chk_zero != bert_pkg::ZERO_RUN_MAX)
         begin
            next_r.chk_zero = r.chk_zero + 5'h01;
         end
      end

      // ==========================================
      // Error counter, a clear in the same cycle as a counted error leaves a count of one
      if (chk_take & mismatch & r.locked)
      begin
         if (clear_count)
         begin
            next_r.err_count = 8'h01;
         end
         else if (r.err_count != bert_pkg::ERR_COUNT_MAX)
         begin
            next_r.err_count = r.err_count + 8'h01;
         end
      end
      else if (clear_count)
      begin
         next_r.err_count = 8'h00;
      end

      // ==========================================
      // Lock tracking
      case (r.lock_state)
         bert_pkg::HUNTING:
         begin
            if (chk_take)
            begin
               if (mismatch)
               begin
                  next_r.match_run = 6'h00;
               end
               else if (r.match_run + 6'h01 == bert_pkg::LOCK_MATCHES)
               begin
                  next_r.lock_state = bert_pkg::LOCKED;
                  next_r.locked = 1'b1;
                  next_r.miss_run = 3'h0;
                  next_r.match_run = 6'h00;
               end
               else
               begin
                  next_r.match_run = r.match_run + 6'h01;
               end
            end
         end
         bert_pkg::LOCKED:
         begin
            if (chk_take)
            begin
               if (!mismatch)
               begin
                  next_r.miss_run = 3'h0;
               end
               else if (r.miss_run + 3'h1 == bert_pkg::UNLOCK_MISSES)
               begin
                  next_r.lock_state = bert_pkg::HUNTING;
                  next_r.locked = 1'b0;
                  next_r.miss_run = 3'h0;
               end
               else
               begin
                  next_r.miss_run = r.miss_run + 3'h1;
               end
            end
         end
         default:
         begin
            next_r.lock_state = bert_pkg::HUNTING;
            next_r.locked = 1'b0;
            next_r.match_run = 6'h00;
            next_r.miss_run = 3'h0;
         end
      endcase
      if (!chk_en)
      begin
         next_r.lock_state = bert_pkg::HUNTING;
         next_r.locked = 1'b0;
         next_r.match_run = 6'h00;
         next_r.miss_run = 3'h0;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r.control_one <= bert_pkg::CONTROL_ONE_RESET;
         r.config_bits <= bert_pkg::CONFIG_RESET;
         r.ack <= 1'b0;
         r.rdata <= 32'h00000000;
         r.insert_prev <= 1'b0;
         r.insert_pending <= 1'b0;
         r.gen_hist <= bert_pkg::GEN_SEED;
         r.gen_zero <= 5'h00;
         r.chk_hist <= 20'h00000;
         r.chk_zero <= 5'h00;
         r.lock_state <= bert_pkg::HUNTING;
         r.locked <= 1'b0;
         r.match_run <= 6'h00;
         r.miss_run <= 3'h0;
         r.err_count <= 8'h00;
      end
      else if (ce_i)
      begin
         r <= next_r;
      end
   end

   // ==========================================
   // Outputs
   assign wb_dat_o = r.rdata;
   assign wb_ack_o = r.ack;
   assign lock_o = r.locked;
endmodule

/* bert_pattern_control_props.sv */
// Concurrent checks on the ports of the test pattern block
`timescale 1ns/1ps
module bert_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic out_valid_o,
   input wire logic out_data_o,
   input wire logic out_to_backplane_o,
   input wire logic out_ready_i,
   input wire logic lock_o
);
   // ==========================================
   // Bus answer and stream hold
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence read_at(a);
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i && !wb_we_i && wb_adr_i[7:2] == a;
   endsequence
   chk_ack_answer: assert property (take |=> wb_ack_o)
      else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_idle: assert property (!wb_cyc_i && ce_i |=> !wb_ack_o)
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("data outside ack");
   chk_ctl_zero: assert property (read_at(6'h00) |=> wb_dat_o[31:8] == 24'h000000 && wb_dat_o[4:0] == 5'h00)
      else $error("unused control bits set");
   chk_unmapped_read: assert property (read_at(6'h03) |=> wb_dat_o == 32'h00000000)
      else $error("unmapped read nonzero");
   chk_out_hold: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(out_data_o) && $stable(out_to_backplane_o))
      else $error("stalled bit changed");
   chk_freeze_state: assert property (!ce_i |=> $stable(lock_o) && $stable(out_valid_o) && $stable(out_data_o))
      else $error("state moved while frozen");
   chk_reset_idle: assert property ($past(rst_i) |-> !lock_o && !out_valid_o && !wb_ack_o)
      else $error("outputs not idle after reset");
endmodule
bind bert_pattern_control bert_props chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_to_backplane_o(out_to_backplane_o),
   .out_ready_i(out_ready_i), .lock_o(lock_o));

/* bert_line_model.sv */
// Far side stand-in: stalling sink and pattern source
`timescale 1ns/1ps
module bert_line_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic valid_i,
   input wire logic data_i,
   input wire logic flag_i,
   input wire logic inv_i,
   output logic ready_o,
   output logic tx_valid_o,
   output logic tx_data_o
);
   logic [14:0] lfsr = 15'h0001;
   logic cap[$];
   logic flg[$];
   initial
   begin
      ready_o = 1'b0;
      tx_valid_o = 1'b0;
      tx_data_o = 1'b0;
   end
   // ==========================================
   // Sink with random stalls, source with gaps
   always @(posedge clk_i)
   begin
      if (valid_i && ready_o && ce_i && !rst_i)
      begin
         cap.push_back(data_i);
         flg.push_back(flag_i);
      end
      ready_o <= $urandom_range(3) != 0;
      if ($urandom_range(1) && !rst_i)
      begin
         lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
         tx_valid_o <= 1'b1;
         tx_data_o <= lfsr[14] ^ lfsr[13] ^ inv_i;
      end
      else
      begin
         tx_valid_o <= 1'b0;
         tx_data_o <= !tx_data_o;
      end
   end
endmodule

/* bert_pattern_control_test.sv */
// Self-checking bench for the test pattern block
`timescale 1ns/1ps
module bert_pattern_control_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic sinv = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] rd;
   logic ack, ov, od, ob, ordy, iv, id, lock;
   int fail_count = 0;
   int checks = 0;
   always #2.5 clk_i = ~clk_i;
   bert_pattern_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .out_valid_o(ov), .out_data_o(od), .out_to_backplane_o(ob), .out_ready_i(ordy), .in_valid_i(iv),
      .in_data_i(id), .lock_o(lock));
   bert_line_model line (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .valid_i(ov), .data_i(od), .flag_i(ob),
      .inv_i(sinv), .ready_o(ordy), .tx_valid_o(iv), .tx_data_o(id));
   // ==========================================
   // Compare, bus cycle and stream model
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do
         @(posedge clk_i);
      while (ack !== 1'b1 && ++n < 100);
      q = rd;
      cyc <= 1'b0;
      chk(ack, 1'b1);
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic grab(input logic c, input int n);
      int k;
      k = 0;
      if (c)
      begin
         line.cap.delete();
         line.flg.delete();
      end
      while (line.cap.size() < n && k++ < 9000)
         @(posedge clk_i);
      chk(line.cap.size() >= n, 1);
   endtask
   task automatic waitlock(input logic e);
      int k;
      k = 0;
      while (lock !== e && k++ < 2000)
         @(posedge clk_i);
      chk(lock, e);
   endtask
   function automatic int mism(int from, logic inv, logic fl);
      int m;
      m = 0;
      for (int n = from; n < line.cap.size(); n++)
         if ((line.cap[n] ^ line.cap[n-15] ^ line.cap[n-14]) !== inv || line.flg[n] !== fl)
            m++;
      return m;
   endfunction
   function automatic int zrun();
      int z, mx;
      z = 0;
      mx = 0;
      for (int n = 5; n < line.cap.size(); n++)
      begin
         z = line.cap[n] ? 0 : z + 1;
         mx = z > mx ? z : mx;
      end
      return mx;
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial
   begin
      logic [31:0] r;
      void'($urandom(41860));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 16; a += 4)
         rdc(8'(a), 32'h0);
      r = $urandom;
      wr(8'h00, r);
      rdc(8'h00, r & 32'h000000E0);
      $display("done registers");
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h04, 32'(2 | c[0]));
         wr(8'h00, 32'(c[1]) << 5);
         grab(1, 120);
         ce_i <= 1'b0;
         repeat (3) @(posedge clk_i);
         ce_i <= 1'b1;
         grab(0, 240);
         chk(mism(20, c[1], c[0]), 0);
      end
      $display("done routing and inversion");
      for (int s = 0; s < 2; s++)
      begin
         wr(8'h04, 32'(2 | s));
         wr(8'h00, 32'h0);
         grab(1, 30);
         wr(8'h00, 32'h40);
         grab(0, 150);
         chk(mism(20, 0, s[0]), 3);
         grab(1, 100);
         chk(mism(15, 0, s[0]), 0);
      end
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h40);
      grab(1, 0);
      wr(8'h04, 32'h2);
      grab(0, 200);
      chk(mism(15, 0, 0), 0);
      $display("done error insertion");
      wr(8'h00, 32'h80);
      grab(1, 400);
      chk(zrun() <= 14, 1);
      chk(mism(40, 0, 0) > 0, 1);
      $display("done quasi-random");
      wr(8'h04, 32'h0);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h00, 32'(c[1]) << 5);
         wr(8'h04, 32'(4 | c[0]));
         sinv <= c[1];
         waitlock(1'b1);
         sinv <= !c[1];
         waitlock(1'b0);
      end
      wr(8'h00, 32'h80);
      wr(8'h04, 32'h4);
      repeat (400) @(posedge clk_i);
      chk(lock, 1'b0);
      $display("done checker");
      end_sim();
   end
   initial
   begin
      #100us;
      fail_count++;
      end_sim();
   end
endmodule
